// *** sdc_cfg.svh ***
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Frame layout.
`define SDC_WORD_BITS     16
`define SDC_WORD_MSB      15
`define SDC_CODE_TOP      15
`define SDC_CODE_MID      14
`define SDC_CODE_LOW      13
`define SDC_DATA_MSB      12
`define SDC_DATA_LSB      1
`define SDC_SUB_BIT       0
`define SDC_SPLIT_LAST    4'h7
`define SDC_LAST_BIT      4'hf

// Bit counter of the receiving end; it saturates one past a full word.
`define SDC_CNT_ONE       5'h01
`define SDC_CNT_FULL      5'h10
`define SDC_CNT_OVER      5'h11

// Low two bits of the control code.
`define SDC_OP_LOAD_BOTH  2'h0
`define SDC_OP_LOAD_IN    2'h1
`define SDC_OP_RECALL     2'h2
`define SDC_OP_SPECIAL    2'h3

// Reset values.
`define SDC_DAC_RST       13'h0000
`define SDC_WORD_RST      16'h0000

// Host timing.
`define SDC_PCLK_NS       25
`define SDC_HALF_NS       75
`define SDC_GAP_NS        400
`define SDC_CSW_NS        200
`define SDC_SETTLE_US     20
`define SDC_HALF_CYC      ((`SDC_HALF_NS + `SDC_PCLK_NS - 1) / `SDC_PCLK_NS)
`define SDC_GAP_CYC       ((`SDC_GAP_NS + `SDC_PCLK_NS - 1) / `SDC_PCLK_NS)
`define SDC_CSW_CYC       ((`SDC_CSW_NS + `SDC_PCLK_NS - 1) / `SDC_PCLK_NS)
`define SDC_SETTLE_CYC    ((`SDC_SETTLE_US * 1000 + `SDC_PCLK_NS - 1) / `SDC_PCLK_NS)

// Host register map and fields.
`define SDC_REG_CMD       8'h00
`define SDC_REG_STATUS    8'h04
`define SDC_REG_CTRL      8'h08
`define SDC_ST_BUSY       0
`define SDC_ST_SETTLING   1
`define SDC_ST_LOST       2
`define SDC_CTRL_SPLIT    0

`endif

// *** sdc_pkg.sv ***
package sdc_pkg;

    typedef logic [15:0] sdc_word_t;
    typedef logic [12:0] sdc_dac_t;
    typedef logic [4:0]  sdc_cnt_t;

    typedef enum logic [2:0] {
        st_idle,
        st_lead,
        st_clk_hi,
        st_clk_lo,
        st_pause,
        st_tail,
        st_rest
    } sdc_host_state_t;

endpackage : sdc_pkg

// *** sdc_link_if.sv ***
`timescale 1ns/10ps

interface sdc_link_if;
    logic sclk;
    logic cs_n;
    logic din;

    modport dev (
        input sclk,
        input cs_n,
        input din
    );

    modport host (
        output sclk,
        output cs_n,
        output din
    );
endinterface : sdc_link_if

// *** sdc_dev.sv ***
`timescale 1ns/10ps
`include "sdc_cfg.svh"

// The receiving end of the three-wire command link. Bits are gathered on
// the serial clock; the finished word is judged and applied on pclk once
// the chip-select release has been seen through a synchroniser.
module sdc_dev (
    input  wire logic        pclk,
    input  wire logic        presetn,
    sdc_link_if.dev          link,
    output logic [12:0]      dac_code,
    output logic [12:0]      input_code,
    output logic             power_down,
    output logic             cmd_taken,
    output logic             frame_dropped
);

    // Serial clock domain.
    sdc_pkg::sdc_word_t shift_reg;
    sdc_pkg::sdc_cnt_t  bit_cnt_reg;
    logic               first_reg;
    logic               frame_tgl_reg;

    // Main clock domain.
    logic               cs_sync1_reg;
    logic               cs_sync2_reg;
    logic               cs_sync3_reg;
    logic               cs_rise;
    logic               seen_tgl_reg;
    logic               word_ok;
    sdc_pkg::sdc_word_t word;
    sdc_pkg::sdc_dac_t  field;
    sdc_pkg::sdc_dac_t  input_reg;
    sdc_pkg::sdc_dac_t  input_next;
    sdc_pkg::sdc_dac_t  dac_reg;
    sdc_pkg::sdc_dac_t  dac_next;
    logic               pd_reg;
    logic               pd_next;
    logic               taken_reg;
    logic               dropped_reg;
    logic               load_in;
    logic               load_dac;
    logic               copy_in;
    logic               enter_pd;
    logic               leave_pd;

    // The flag is forced high while chip-select is high, so the first
    // rising edge of a frame restarts the count. The count itself is not
    // cleared by chip-select, so it is still readable after the release.
    always_ff @(posedge link.sclk or posedge link.cs_n or negedge presetn) begin
        if (!presetn || link.cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_ff @(posedge link.sclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= `SDC_WORD_RST;
        end else if (!link.cs_n) begin
            shift_reg <= {shift_reg[`SDC_WORD_MSB-1:0], link.din};
        end
    end

    // Edges taken with chip-select high are ignored, so shutdown or idle
    // time does not disturb a word already gathered.
    always_ff @(posedge link.sclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 5'h00;
        end else if (!link.cs_n) begin
            if (first_reg) begin
                bit_cnt_reg <= `SDC_CNT_ONE;
            end else if (bit_cnt_reg != `SDC_CNT_OVER) begin
                bit_cnt_reg <= bit_cnt_reg + `SDC_CNT_ONE;
            end
        end
    end

    // Flips once for every frame that saw a clock edge, so a select pulse
    // with no edges cannot commit the word left over from the frame before.
    always_ff @(posedge link.sclk or negedge presetn) begin
        if (!presetn) begin
            frame_tgl_reg <= 1'b0;
        end else if (!link.cs_n && first_reg) begin
            frame_tgl_reg <= !frame_tgl_reg;
        end
    end

    // Chip-select enters pclk through two flops; the third flop only
    // serves the edge detector and never sees the raw pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync1_reg <= 1'b1;
            cs_sync2_reg <= 1'b1;
            cs_sync3_reg <= 1'b1;
        end else begin
            cs_sync1_reg <= link.cs_n;
            cs_sync2_reg <= cs_sync1_reg;
            cs_sync3_reg <= cs_sync2_reg;
        end
    end

    assign cs_rise = cs_sync2_reg && !cs_sync3_reg;

    // The shift register and counter are quiet while chip-select is high,
    // so reading them three pclk edges after its release is safe. A host that
    // restarts a frame sooner than three pclk periods defeats this.
    assign word    = shift_reg;
    assign word_ok = (bit_cnt_reg == `SDC_CNT_FULL)
                  && (frame_tgl_reg != seen_tgl_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_tgl_reg <= 1'b0;
        end else if (cs_rise) begin
            seen_tgl_reg <= frame_tgl_reg;
        end
    end
    assign field   = word[`SDC_DATA_MSB:`SDC_SUB_BIT];

    always_comb begin
        load_in  = 1'b0;
        load_dac = 1'b0;
        copy_in  = 1'b0;
        enter_pd = 1'b0;
        leave_pd = 1'b0;
        if (cs_rise && word_ok) begin
            unique case (word[`SDC_CODE_MID:`SDC_CODE_LOW])
                `SDC_OP_LOAD_BOTH: begin
                    load_in  = 1'b1;
                    load_dac = 1'b1;
                    leave_pd = 1'b1;
                end
                `SDC_OP_LOAD_IN: begin
                    load_in  = 1'b1;
                end
                `SDC_OP_RECALL: begin
                    copy_in  = 1'b1;
                    leave_pd = 1'b1;
                end
                `SDC_OP_SPECIAL: begin
                    enter_pd = word[`SDC_CODE_TOP];
                end
            endcase
        end
    end

    always_comb begin
        input_next = input_reg;
        if (load_in) begin
            input_next = field;
        end
    end

    always_comb begin
        dac_next = dac_reg;
        if (load_dac) begin
            dac_next = field;
        end else if (copy_in) begin
            dac_next = input_reg;
        end
    end

    // A shutdown word and an exit word cannot arrive in the same frame,
    // so the order of the two tests below is free.
    always_comb begin
        pd_next = pd_reg;
        if (enter_pd) begin
            pd_next = 1'b1;
        end else if (leave_pd) begin
            pd_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_reg <= `SDC_DAC_RST;
        end else begin
            input_reg <= input_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_reg <= `SDC_DAC_RST;
        end else begin
            dac_reg <= dac_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_reg <= 1'b0;
        end else begin
            pd_reg <= pd_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_reg   <= 1'b0;
            dropped_reg <= 1'b0;
        end else begin
            taken_reg   <= cs_rise && word_ok;
            dropped_reg <= cs_rise && !word_ok;
        end
    end

    assign dac_code      = dac_reg;
    assign input_code    = input_reg;
    assign power_down    = pd_reg;
    assign cmd_taken     = taken_reg;
    assign frame_dropped = dropped_reg;

endmodule : sdc_dev

// *** sdc_host.sv ***
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "sdc_cfg.svh"

// The sending end: an APB slave for software and a divider-clocked
// three-wire master toward the converter.
module sdc_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    sdc_link_if.host         link
);

    localparam int HALF_CYC   = `SDC_HALF_CYC;
    localparam int GAP_CYC    = `SDC_GAP_CYC;
    localparam int CSW_CYC    = `SDC_CSW_CYC;
    localparam int SETTLE_CYC = `SDC_SETTLE_CYC;

    sdc_pkg::sdc_host_state_t state_reg;
    sdc_pkg::sdc_word_t       word_reg;
    sdc_pkg::sdc_word_t       tx_reg;
    logic [3:0]               bit_idx_reg;
    logic [7:0]               timer_reg;
    logic [9:0]               settle_reg;
    logic                     exit_reg;
    logic                     split_reg;
    logic                     lost_reg;
    logic                     sclk_reg;
    logic                     cs_n_reg;
    logic                     din_reg;
    logic [31:0]              prdata_reg;
    logic                     mapped;
    logic                     wr;
    logic                     busy;
    logic                     start;
    logic                     half_done;
    sdc_pkg::sdc_word_t       send_word;

    assign mapped    = (paddr == `SDC_REG_CMD) || (paddr == `SDC_REG_STATUS)
                    || (paddr == `SDC_REG_CTRL);
    assign wr        = psel && penable && pwrite && mapped;
    assign busy      = (state_reg != sdc_pkg::st_idle);
    assign start     = wr && (paddr == `SDC_REG_CMD) && !busy;
    assign half_done = (timer_reg == 8'(HALF_CYC - 1));
    assign pready    = psel && penable;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = prdata_reg;

    // Data-loading words always leave with the sub-bit cleared.
    always_comb begin
        send_word = pwdata[`SDC_WORD_MSB:0];
        if (!pwdata[`SDC_CODE_MID]) begin
            send_word[`SDC_SUB_BIT] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_reg <= 32'h0000_0000;
            unique case (paddr)
                `SDC_REG_CMD:    prdata_reg[`SDC_WORD_MSB:0] <= word_reg;
                `SDC_REG_STATUS: begin
                    prdata_reg[`SDC_ST_BUSY]     <= busy;
                    prdata_reg[`SDC_ST_SETTLING] <= (settle_reg != 10'h000);
                    prdata_reg[`SDC_ST_LOST]     <= lost_reg;
                end
                `SDC_REG_CTRL:   prdata_reg[`SDC_CTRL_SPLIT] <= split_reg;
                default:         prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_reg <= 1'b0;
        end else if (wr && paddr == `SDC_REG_CTRL) begin
            split_reg <= pwdata[`SDC_CTRL_SPLIT];
        end
    end

    // A command written while a frame is on the wire is dropped and noted;
    // a new loss in the clearing cycle keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_reg <= 1'b0;
        end else if (wr && paddr == `SDC_REG_CMD && busy) begin
            lost_reg <= 1'b1;
        end else if (wr && paddr == `SDC_REG_STATUS && pwdata[`SDC_ST_LOST]) begin
            lost_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= `SDC_WORD_RST;
            exit_reg <= 1'b0;
        end else if (start) begin
            word_reg <= send_word;
            exit_reg <= !send_word[`SDC_CODE_LOW];
        end
    end

    // Settling starts at power-up and again after any word that leaves
    // shutdown; software polls it before trusting the analog level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_reg <= 10'(SETTLE_CYC);
        end else if (state_reg == sdc_pkg::st_tail && half_done && exit_reg) begin
            settle_reg <= 10'(SETTLE_CYC);
        end else if (settle_reg != 10'h000) begin
            settle_reg <= settle_reg - 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= sdc_pkg::st_idle;
            timer_reg   <= 8'h00;
            bit_idx_reg <= 4'h0;
            tx_reg      <= `SDC_WORD_RST;
            sclk_reg    <= 1'b0;
            cs_n_reg    <= 1'b1;
            din_reg     <= 1'b0;
        end else begin
            timer_reg <= timer_reg + 8'h01;
            unique case (state_reg)
                sdc_pkg::st_idle: begin
                    timer_reg <= 8'h00;
                    if (start) begin
                        tx_reg      <= send_word;
                        din_reg     <= send_word[`SDC_WORD_MSB];
                        cs_n_reg    <= 1'b0;
                        bit_idx_reg <= 4'h0;
                        state_reg   <= sdc_pkg::st_lead;
                    end
                end
                sdc_pkg::st_lead, sdc_pkg::st_clk_lo: begin
                    if (half_done) begin
                        timer_reg <= 8'h00;
                        sclk_reg  <= 1'b1;
                        state_reg <= sdc_pkg::st_clk_hi;
                    end
                end
                sdc_pkg::st_clk_hi: begin
                    if (half_done) begin
                        timer_reg <= 8'h00;
                        sclk_reg  <= 1'b0;
                        if (bit_idx_reg == `SDC_LAST_BIT) begin
                            state_reg <= sdc_pkg::st_tail;
                        end else begin
                            bit_idx_reg <= bit_idx_reg + 4'h1;
                            tx_reg      <= {tx_reg[`SDC_WORD_MSB-1:0], 1'b0};
                            din_reg     <= tx_reg[`SDC_WORD_MSB-1];
                            if (split_reg && bit_idx_reg == `SDC_SPLIT_LAST) begin
                                state_reg <= sdc_pkg::st_pause;
                            end else begin
                                state_reg <= sdc_pkg::st_clk_lo;
                            end
                        end
                    end
                end
                sdc_pkg::st_pause: begin
                    if (timer_reg == 8'(GAP_CYC - 1)) begin
                        timer_reg <= 8'h00;
                        state_reg <= sdc_pkg::st_clk_lo;
                    end
                end
                sdc_pkg::st_tail: begin
                    if (half_done) begin
                        timer_reg <= 8'h00;
                        cs_n_reg  <= 1'b1;
                        state_reg <= sdc_pkg::st_rest;
                    end
                end
                sdc_pkg::st_rest: begin
                    if (timer_reg == 8'(CSW_CYC - 1)) begin
                        timer_reg <= 8'h00;
                        state_reg <= sdc_pkg::st_idle;
                    end
                end
                default: begin
                    state_reg <= sdc_pkg::st_idle;
                    cs_n_reg  <= 1'b1;
                    sclk_reg  <= 1'b0;
                end
            endcase
        end
    end

    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_n_reg;
    assign link.din  = din_reg;

endmodule : sdc_host

// *** sdc_link_sva.sv ***
`timescale 1ns/10ps

module sdc_link_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        din,
    input wire logic [12:0] dac_code,
    input wire logic [12:0] input_code,
    input wire logic        power_down,
    input wire logic        cmd_taken,
    input wire logic        frame_dropped
);
    logic        sclk_reg;
    logic        cs_reg;
    logic [4:0]  cnt_reg;
    logic [15:0] word_reg;

    // The serial clock is seen through pclk; a half period lasts three pclk cycles, except the low half stretched to 19 by the split pause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_reg <= 1'b0;
            cs_reg   <= 1'b1;
            cnt_reg  <= 5'h00;
            word_reg <= 16'h0000;
        end else begin
            sclk_reg <= sclk;
            cs_reg   <= cs_n;
            if (cs_reg) begin
                cnt_reg <= 5'h00;
            end else if (sclk && !sclk_reg) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
            if (sclk && !sclk_reg && !cs_n) begin
                word_reg <= {word_reg[14:0], din};
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_idle_low; cs_n |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("serial clock high while deselected");
    property p_din_hold; sclk && sclk_reg |-> $stable(din); endproperty
    a_din_hold: assert property (p_din_hold)
        else $error("data moved while serial clock high");
    property p_count; cs_n && !cs_reg |-> cnt_reg == 5'h10; endproperty
    a_count: assert property (p_count)
        else $error("frame closed without sixteen bits");
    property p_commit; cs_n && !cs_reg |-> ##[2:5] cmd_taken; endproperty
    a_commit: assert property (p_commit)
        else $error("frame not applied after deselect");
    property p_hold_sel;
        !cs_n |-> $stable(dac_code) && $stable(input_code) && $stable(power_down);
    endproperty
    a_hold_sel: assert property (p_hold_sel)
        else $error("state changed while selected");
    property p_only_cmd;
        !$stable(dac_code) || !$stable(input_code) || !$stable(power_down) |-> cmd_taken;
    endproperty
    a_only_cmd: assert property (p_only_cmd)
        else $error("state changed without a command");
    property p_load_both;
        cmd_taken && word_reg[14:13] == 2'h0 |->
            dac_code == word_reg[12:0] && input_code == word_reg[12:0] && !power_down;
    endproperty
    a_load_both: assert property (p_load_both)
        else $error("load both wrong");
    property p_load_in;
        cmd_taken && word_reg[14:13] == 2'h1 |->
            input_code == word_reg[12:0] && $stable(dac_code) && $stable(power_down);
    endproperty
    a_load_in: assert property (p_load_in)
        else $error("load input wrong");
    property p_recall;
        cmd_taken && word_reg[14:13] == 2'h2 |-> dac_code == input_code && !power_down;
    endproperty
    a_recall: assert property (p_recall)
        else $error("recall wrong");
    property p_down;
        cmd_taken && word_reg[15:13] == 3'h7 |->
            power_down && $stable(dac_code) && $stable(input_code);
    endproperty
    a_down: assert property (p_down)
        else $error("shutdown wrong");
    property p_nop;
        cmd_taken && word_reg[15:13] == 3'h3 |->
            $stable(power_down) && $stable(dac_code) && $stable(input_code);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no operation changed state");
    property p_no_drop; !frame_dropped; endproperty
    a_no_drop: assert property (p_no_drop)
        else $error("full frame dropped");
endmodule : sdc_link_sva

// *** tb_top.sv ***
`timescale 1ns/10ps

module tb_top;
    logic               pclk = 1'b0;
    logic               presetn = 1'b1;
    logic        [7:0]  paddr = 8'h00;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic        [31:0] pwdata = 32'h0000_0000;
    logic        [31:0] prdata;
    logic               pready;
    logic               pslverr;
    logic        [12:0] d1_dac, d1_in, d2_dac, d2_in;
    logic               d1_pd, d1_tk, d1_dr, d2_pd, d2_tk, d2_dr;
    logic               sfree = 1'b0;
    logic               gate2 = 1'b0;
    logic               cs2 = 1'b1;
    logic               din2 = 1'b0;
    int                 mismatches = 0;
    int                 checked = 0;
    int                 seed = 4003;
    sdc_pkg::sdc_dac_t  ein = 13'h0000;
    sdc_pkg::sdc_dac_t  edac = 13'h0000;
    logic               epd = 1'b0;
    logic        [31:0] r;
    logic               e;
    sdc_pkg::sdc_word_t corner [8] = '{16'h1ffe, 16'he123, 16'h3002, 16'h4fff,
                                       16'he000, 16'h0ffe, 16'h6abc, 16'hf555};

    sdc_link_if lk ();
    sdc_link_if lk2 ();
    // The second link is driven by the bench so that broken frames can be sent.
    assign lk2.sclk = sfree & gate2;
    assign lk2.cs_n = cs2;
    assign lk2.din  = din2;

    always #12.5 pclk = ~pclk;
    always #80 sfree = ~sfree;

    sdc_host u_sdc_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(lk));
    sdc_dev u_sdc_dev (.pclk(pclk), .presetn(presetn), .link(lk), .dac_code(d1_dac),
        .input_code(d1_in), .power_down(d1_pd), .cmd_taken(d1_tk), .frame_dropped(d1_dr));
    sdc_dev u_sdc_dev2 (.pclk(pclk), .presetn(presetn), .link(lk2), .dac_code(d2_dac),
        .input_code(d2_in), .power_down(d2_pd), .cmd_taken(d2_tk), .frame_dropped(d2_dr));
    sdc_link_sva u_sdc_link_sva (.pclk(pclk), .presetn(presetn), .sclk(lk.sclk),
        .cs_n(lk.cs_n), .din(lk.din), .dac_code(d1_dac), .input_code(d1_in),
        .power_down(d1_pd), .cmd_taken(d1_tk), .frame_dropped(d1_dr));

    function automatic sdc_pkg::sdc_word_t sent(input sdc_pkg::sdc_word_t w);
        return {w[15:1], w[0] & w[14]};
    endfunction : sent

    function automatic void apply(input sdc_pkg::sdc_word_t w);
        case (w[14:13])
            2'h0: begin
                ein = w[12:0];
                edac = w[12:0];
                epd = 1'b0;
            end
            2'h1: ein = w[12:0];
            2'h2: begin
                edac = ein;
                epd = 1'b0;
            end
            default: if (w[15]) epd = 1'b1;
        endcase
    endfunction : apply

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic hang();
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        final_report();
    endtask : hang

    task automatic check_code(input sdc_pkg::sdc_dac_t got, input sdc_pkg::sdc_dac_t exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t code %h expected %h", $time, got, exp);
        end
    endtask : check_code

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) hang();
    endtask : apb

    task automatic wait_ev(input logic two);
        int n;
        for (n = 0; n < 600; n++) begin
            @(posedge pclk);
            if (two ? (d2_tk === 1'b1 || d2_dr === 1'b1) : d1_tk === 1'b1) break;
        end
        if (n == 600) hang();
    endtask : wait_ev

    task automatic idle();
        int n;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, 8'h04, 32'h0000_0000);
            if (r[0] === 1'b0) break;
        end
        if (n == 40) hang();
    endtask : idle

    task automatic host_frame(input sdc_pkg::sdc_word_t w, input logic split);
        apb(1'b1, 8'h08, {31'h0000_0000, split});
        apb(1'b1, 8'h00, {16'h0000, w});
        apply(sent(w));
        wait_ev(1'b0);
        check_code(d1_dac, edac);
        check_code(d1_in, ein);
        check_bit(d1_pd, epd);
        idle();
    endtask : host_frame

    // Counts other than sixteen must be dropped; the line is inverted after the last clock, before chip-select is released.
    task automatic send2(input logic [16:0] v, input int n);
        int i;
        @(negedge sfree);
        cs2 <= 1'b0;
        gate2 <= 1'b1;
        din2 <= v[n-1];
        for (i = n - 2; i >= 0; i--) begin
            @(negedge sfree);
            din2 <= v[i];
        end
        @(negedge sfree);
        gate2 <= 1'b0;
        din2 <= ~din2;
        @(negedge sfree);
        cs2 <= 1'b1;
        wait_ev(1'b1);
    endtask : send2

    initial begin
        // A real falling edge, so every asynchronous reset branch runs.
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_code(d1_dac, 13'h0000);
        check_code(d1_in, 13'h0000);
        check_code(d2_dac, 13'h0000);
        check_bit(d1_pd, 1'b0);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check_bit(r[1], 1'b1);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check_bit(e, 1'b1);
        check_word(r, 32'h0000_0000);
        for (int i = 0; i < 8; i++) host_frame(corner[i], i[0]);
        apb(1'b1, 8'h00, 32'h0000_2aa8);
        apb(1'b1, 8'h00, 32'h0000_0ffe);
        apply(16'h2aa8);
        wait_ev(1'b0);
        check_code(d1_in, ein);
        check_code(d1_dac, edac);
        idle();
        apb(1'b0, 8'h04, 32'h0000_0000);
        check_bit(r[2], 1'b1);
        apb(1'b1, 8'h04, 32'h0000_0004);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check_bit(r[2], 1'b0);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check_word(r, 32'h0000_2aa8);
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            host_frame(r[15:0], r[16]);
        end
        send2(17'h0_0abc, 16);
        check_bit(d2_tk, 1'b1);
        check_code(d2_dac, 13'h0abc);
        send2(17'h0_3002, 16);
        check_code(d2_in, 13'h1002);
        foreach (corner[i]) begin
            if (i < 3) begin
                send2(17'h1_e0f5, i == 0 ? 8 : (i == 1 ? 15 : 17));
                check_bit(d2_dr, 1'b1);
                check_code(d2_dac, 13'h0abc);
                check_code(d2_in, 13'h1002);
                check_bit(d2_pd, 1'b0);
            end
        end
        final_report();
    end
endmodule : tb_top
